// ---- hdl/pae_alarm_eval.sv ----
// Process alarm evaluator: per-alarm comparison, standby, delays, routing
`timescale 1ns/1ps

// Contract
// - Each alarm picks its type from a code; 0 disables, reset default 2.
// - Each alarm output has on and off delays of 0 to 999 seconds.
// - Each auxiliary output shows the alarm chosen by its assignment.
// - With heater option, alarm 1 follows heater alarm unless assigned.
// - Type 1: alarm when value lies outside setpoint minus low, plus high.
// - Type 2: alarm when value exceeds setpoint by at least alarm value.
// - Type 3: alarm when value is below setpoint by at least alarm value.
// - Type 4: alarm when value lies inside the deviation band.
// - Types 5, 6, 7 are types 1, 2, 3 with standby.
// - Type 8: alarm when process value above alarm value.
// - Type 9: alarm when process value below alarm value.
// - Types 10 and 11 are types 8 and 9 with standby.
// - Code 12 is accepted for alarm 1 only, refused elsewhere.
// - Type 14: alarm when setpoint above alarm value.
// - Type 15: alarm when setpoint below alarm value.
// - Type 16: alarm when manipulated variable above alarm value.
// - Type 17: alarm when manipulated variable below alarm value.
// - Type 18: alarm when remote setpoint above alarm value.
// - Type 19: alarm when remote setpoint below alarm value.
// - Band types keep separate high and low values per alarm.
// - Type 5 stays off while the two hysteresis regions overlap.
// - Heat/cool mode: upper uses heating output, lower uses cooling output.
module pae_alarm_eval
	import pae_pkg::*;
#(
	parameter int HAS_HEATER  = 0,
	parameter int TICK_CYCLES = STEP_CYCLES
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// Register port
	input  wire pae_pkg::pae_bus_s         bus,
	output logic [pae_pkg::DW-1:0]         rdata,
	// Control loop values
	input  wire pae_pkg::pae_loop_s        loop_in,
	input  wire logic                      heater_alarm,
	// Alarm and auxiliary outputs
	output logic [pae_pkg::NUM_ALARMS-1:0] alarm_out,
	output logic [pae_pkg::NUM_AUX-1:0]    aux_out
);
	import pae_pkg::*;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic pae_wide_t wide(input logic [DW-1:0] v);
		wide = pae_wide_t'(signed'(v));
	endfunction

	// Upper comparison; once on, stays on until hysteresis is cleared
	function automatic logic over(input pae_wide_t v, input pae_wide_t lim,
		input pae_wide_t hys, input logic prev, input logic incl);
		if (prev) begin
			over = v > lim - hys;
		end else if (incl) begin
			over = v >= lim;
		end else begin
			over = v > lim;
		end
	endfunction

	function automatic logic under(input pae_wide_t v, input pae_wide_t lim,
		input pae_wide_t hys, input logic prev, input logic incl);
		if (prev) begin
			under = v < lim + hys;
		end else if (incl) begin
			under = v <= lim;
		end else begin
			under = v < lim;
		end
	endfunction

	function automatic logic has_standby(input logic [TW-1:0] t);
		has_standby = (t == ALT_BAND_SB) || (t == ALT_DEV_HI_SB) ||
			(t == ALT_DEV_LO_SB) || (t == ALT_ABS_HI_SB) ||
			(t == ALT_ABS_LO_SB);
	endfunction

	// Decodes which alarm block an address falls in; -1 when none
	function automatic int alarm_of(input logic [AW-1:0] a);
		alarm_of = -1;
		if (a[7:4] != 4'h0 && int'(a[7:4]) <= NUM_ALARMS) begin
			alarm_of = int'(a[7:4]) - 1;
		end
	endfunction

	function automatic logic [DLW-1:0] clamp_dly(input logic [DW-1:0] v);
		if (v > {6'h00, DELAY_MAX}) begin
			clamp_dly = DELAY_MAX;
		end else begin
			clamp_dly = v[DLW-1:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

	pae_state_s st_reg;
	pae_state_s st_next;

	logic       alarm1_normal;
	logic       dedicated;
	logic       tick;
	logic       cond;
	logic       overlap;
	logic       raw_n;
	logic [DLW-1:0] lim;
	pae_wide_t  pv;
	pae_wide_t  sp;
	pae_wide_t  hv;
	pae_wide_t  lv;
	pae_wide_t  hy;
	pae_wide_t  mvu;
	pae_wide_t  mvl;
	int         sel;
	int         ai;

	always_comb begin
		alarm1_normal = 1'b0;
		for (int j = 0; j < NUM_AUX; j++) begin
			if (st_reg.aux_sel[j] == SW'(1)) begin
				alarm1_normal = 1'b1;
			end
		end
		dedicated = (HAS_HEATER != 0) && !alarm1_normal;
	end

	always_comb begin
		st_next = st_reg;
		tick = st_reg.tick_cnt == TICK_LAST;
		cond = 1'b0;
		overlap = 1'b0;
		raw_n = 1'b0;
		lim = '0;
		sel = 0;
		ai = alarm_of(bus.addr);
		pv = wide(loop_in.pv);
		sp = wide(loop_in.sp);
		hy = wide(st_reg.hys);
		hv = '0;
		lv = '0;
		mvu = wide(loop_in.mv_heat);
		mvl = st_reg.heat_cool ? wide(loop_in.mv_cool) : wide(loop_in.mv_heat);

		// ------------------------------------------------------------
		// Second tick for the delay counters
		// ------------------------------------------------------------
		st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + TCW'(1);

		// ------------------------------------------------------------
		// Alarm evaluation
		// ------------------------------------------------------------
		for (int i = 0; i < NUM_ALARMS; i++) begin
			hv = wide(st_reg.hi[i]);
			lv = wide(st_reg.lo[i]);
			overlap = hv + lv <= hy + hy;
			case (st_reg.typ[i])
				ALT_BAND_OUT, ALT_BAND_SB: begin
					cond = over(pv, sp + hv, hy, st_reg.raw[i], 1'b0) ||
						under(pv, sp - lv, hy, st_reg.raw[i], 1'b0);
					if (st_reg.typ[i] == ALT_BAND_SB && overlap) begin
						cond = 1'b0;
					end
				end
				ALT_DEV_HI, ALT_DEV_HI_SB: begin
					cond = over(pv, sp + hv, hy, st_reg.raw[i], 1'b1);
				end
				ALT_DEV_LO, ALT_DEV_LO_SB: begin
					cond = under(pv, sp - hv, hy, st_reg.raw[i], 1'b1);
				end
				ALT_BAND_IN: begin
					cond = (pv >= sp - lv) && (pv <= sp + hv);
				end
				ALT_ABS_HI, ALT_ABS_HI_SB: begin
					cond = over(pv, hv, hy, st_reg.raw[i], 1'b0);
				end
				ALT_ABS_LO, ALT_ABS_LO_SB: begin
					cond = under(pv, hv, hy, st_reg.raw[i], 1'b0);
				end
				ALT_SP_HI: begin
					cond = over(sp, hv, hy, st_reg.raw[i], 1'b0);
				end
				ALT_SP_LO: begin
					cond = under(sp, hv, hy, st_reg.raw[i], 1'b0);
				end
				ALT_MV_HI: begin
					cond = over(mvu, hv, hy, st_reg.raw[i], 1'b0);
				end
				ALT_MV_LO: begin
					cond = under(mvl, hv, hy, st_reg.raw[i], 1'b0);
				end
				ALT_RSP_HI: begin
					cond = over(wide(loop_in.rsp), hv, hy,
						st_reg.raw[i], 1'b0);
				end
				ALT_RSP_LO: begin
					cond = under(wide(loop_in.rsp), hv, hy,
						st_reg.raw[i], 1'b0);
				end
				// Loop burnout and rate alarm codes are not evaluated and never raise the alarm
				default: begin
					cond = 1'b0;
				end
			endcase

			// Standby: armed only once the value leaves the alarm region
			if (!cond) begin
				st_next.armed[i] = 1'b1;
			end
			raw_n = cond && (st_reg.armed[i] ||
				!has_standby(st_reg.typ[i]));
			if (i == 0 && dedicated) begin
				raw_n = heater_alarm;
			end
			st_next.raw[i] = raw_n;

			// On and off delays, counted in whole seconds
			lim = st_reg.raw[i] ? st_reg.on_dly[i] : st_reg.off_dly[i];
			if (st_reg.raw[i] == st_reg.out[i]) begin
				st_next.cnt[i] = '0;
			end else if (st_reg.cnt[i] >= lim) begin
				st_next.out[i] = st_reg.raw[i];
				st_next.cnt[i] = '0;
			end else if (tick) begin
				st_next.cnt[i] = st_reg.cnt[i] + DLW'(1);
			end
		end

		// ------------------------------------------------------------
		// Auxiliary output routing
		// ------------------------------------------------------------
		for (int j = 0; j < NUM_AUX; j++) begin
			sel = int'(st_reg.aux_sel[j]);
			if (st_reg.aux_sel[j] == SEL_HEATER) begin
				st_next.aux[j] = (HAS_HEATER != 0) && heater_alarm;
			end else if (sel >= 1 && sel <= NUM_ALARMS) begin
				st_next.aux[j] = st_reg.out[sel-1];
			end else begin
				st_next.aux[j] = 1'b0;
			end
		end

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		if (bus.wr) begin
			if (bus.addr == ADDR_CTRL) begin
				st_next.heat_cool = bus.wdata[CTRL_HEAT_COOL];
				if (bus.wdata[CTRL_RESTART]) begin
					// Mode start re-enters standby for every alarm
					st_next.armed = '0;
				end
			end else if (bus.addr == ADDR_HYS) begin
				st_next.hys = bus.wdata;
			end else if (bus.addr == ADDR_AUX) begin
				for (int j = 0; j < NUM_AUX; j++) begin
					st_next.aux_sel[j] = bus.wdata[j*SW +: SW];
				end
			end else if (ai >= 0) begin
				if (bus.addr[3:0] == OFS_TYPE) begin
					// Unknown codes, foreign burnout codes and hidden
					// alarm 1 leave the type unchanged
					if (bus.wdata[DW-1:TW] == '0 &&
						bus.wdata[TW-1:0] <= ALT_LAST &&
						(bus.wdata[TW-1:0] != ALT_LOOP_BURN || ai == 0) &&
						!(ai == 0 && dedicated)) begin
						st_next.typ[ai] = bus.wdata[TW-1:0];
						st_next.armed[ai] = 1'b0;
					end
				end else if (bus.addr[3:0] == OFS_HI) begin
					st_next.hi[ai] = bus.wdata;
				end else if (bus.addr[3:0] == OFS_LO) begin
					st_next.lo[ai] = bus.wdata;
				end else if (bus.addr[3:0] == OFS_ON_DLY) begin
					st_next.on_dly[ai] = clamp_dly(bus.wdata);
				end else if (bus.addr[3:0] == OFS_OFF_DLY) begin
					st_next.off_dly[ai] = clamp_dly(bus.wdata);
				end
			end
		end

		// ------------------------------------------------------------
		// Register reads, answered in the following cycle
		// ------------------------------------------------------------
		st_next.rdata = '0;
		if (bus.rd) begin
			if (bus.addr == ADDR_CTRL) begin
				st_next.rdata[CTRL_HEAT_COOL] = st_reg.heat_cool;
			end else if (bus.addr == ADDR_HYS) begin
				st_next.rdata = st_reg.hys;
			end else if (bus.addr == ADDR_AUX) begin
				st_next.rdata[NUM_AUX*SW-1:0] = st_reg.aux_sel;
			end else if (bus.addr == ADDR_STAT) begin
				st_next.rdata[NUM_ALARMS-1:0] = st_reg.raw;
				st_next.rdata[STAT_OUT_POS +: NUM_ALARMS] = st_reg.out;
			end else if (ai >= 0) begin
				if (bus.addr[3:0] == OFS_TYPE) begin
					st_next.rdata[TW-1:0] =
						(ai == 0 && dedicated) ? ALT_OFF : st_reg.typ[ai];
				end else if (bus.addr[3:0] == OFS_HI) begin
					st_next.rdata = st_reg.hi[ai];
				end else if (bus.addr[3:0] == OFS_LO) begin
					st_next.rdata = st_reg.lo[ai];
				end else if (bus.addr[3:0] == OFS_ON_DLY) begin
					st_next.rdata[DLW-1:0] = st_reg.on_dly[ai];
				end else if (bus.addr[3:0] == OFS_OFF_DLY) begin
					st_next.rdata[DLW-1:0] = st_reg.off_dly[ai];
				end
			end
		end

		// ------------------------------------------------------------
		// Synchronous reset
		// ------------------------------------------------------------
		if (!nrst) begin
			st_next = '0;
			for (int i = 0; i < NUM_ALARMS; i++) begin
				st_next.typ[i] = TYPE_RST;
			end
			st_next.hys = HYS_RST;
			for (int j = 0; j < NUM_AUX; j++) begin
				st_next.aux_sel[j] = SW'(j + 1);
			end
			if (HAS_HEATER != 0) begin
				st_next.aux_sel[0] = SEL_HEATER;
			end
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign rdata     = st_reg.rdata;
	assign alarm_out = st_reg.out;
	assign aux_out   = st_reg.aux;

endmodule

// ---- hdl/pae_pkg.sv ----
// Package for the process alarm evaluator: map, codes, layouts, timing
package pae_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_ALARMS = 3;
	localparam int NUM_AUX    = 2;
	localparam int DW         = 16;
	localparam int TW         = 5;
	localparam int DLW        = 10;
	localparam int SW         = 4;
	localparam int AW         = 8;
	localparam int TCW        = 28;

	typedef logic signed [DW-1:0]  pae_val_t;
	typedef logic signed [DW+1:0]  pae_wide_t;

	// ----------------------------------------------------------------
	// Alarm type codes
	// ----------------------------------------------------------------
	localparam logic [TW-1:0] ALT_OFF        = 5'h00;
	localparam logic [TW-1:0] ALT_BAND_OUT   = 5'h01;
	localparam logic [TW-1:0] ALT_DEV_HI     = 5'h02;
	localparam logic [TW-1:0] ALT_DEV_LO     = 5'h03;
	localparam logic [TW-1:0] ALT_BAND_IN    = 5'h04;
	localparam logic [TW-1:0] ALT_BAND_SB    = 5'h05;
	localparam logic [TW-1:0] ALT_DEV_HI_SB  = 5'h06;
	localparam logic [TW-1:0] ALT_DEV_LO_SB  = 5'h07;
	localparam logic [TW-1:0] ALT_ABS_HI     = 5'h08;
	localparam logic [TW-1:0] ALT_ABS_LO     = 5'h09;
	localparam logic [TW-1:0] ALT_ABS_HI_SB  = 5'h0a;
	localparam logic [TW-1:0] ALT_ABS_LO_SB  = 5'h0b;
	localparam logic [TW-1:0] ALT_LOOP_BURN  = 5'h0c;
	localparam logic [TW-1:0] ALT_RATE       = 5'h0d;
	localparam logic [TW-1:0] ALT_SP_HI      = 5'h0e;
	localparam logic [TW-1:0] ALT_SP_LO      = 5'h0f;
	localparam logic [TW-1:0] ALT_MV_HI      = 5'h10;
	localparam logic [TW-1:0] ALT_MV_LO      = 5'h11;
	localparam logic [TW-1:0] ALT_RSP_HI     = 5'h12;
	localparam logic [TW-1:0] ALT_RSP_LO     = 5'h13;
	localparam logic [TW-1:0] ALT_LAST       = 5'h13;

	// ----------------------------------------------------------------
	// Register map (word addresses)
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [AW-1:0] ADDR_HYS    = 8'h01;
	localparam logic [AW-1:0] ADDR_AUX    = 8'h02;
	localparam logic [AW-1:0] ADDR_STAT   = 8'h03;
	localparam logic [3:0]    OFS_TYPE    = 4'h0;
	localparam logic [3:0]    OFS_HI      = 4'h1;
	localparam logic [3:0]    OFS_LO      = 4'h2;
	localparam logic [3:0]    OFS_ON_DLY  = 4'h3;
	localparam logic [3:0]    OFS_OFF_DLY = 4'h4;
	localparam int            CTRL_HEAT_COOL = 0;
	localparam int            CTRL_RESTART   = 1;
	localparam int            STAT_OUT_POS   = 8;

	// ----------------------------------------------------------------
	// Reset values and selector codes
	// ----------------------------------------------------------------
	localparam logic [TW-1:0]  TYPE_RST  = ALT_DEV_HI;
	localparam logic [DW-1:0]  HYS_RST   = 16'h0001;
	localparam logic [DLW-1:0] DELAY_MAX = 10'h3e7;
	localparam logic [SW-1:0]  SEL_NONE   = 4'h0;
	localparam logic [SW-1:0]  SEL_HEATER = 4'hf;

	// ----------------------------------------------------------------
	// Timing: one delay step is one second
	// ----------------------------------------------------------------
	localparam int CLK_MHZ     = 200;
	localparam int STEP_US     = 1000000;
	localparam int STEP_CYCLES = STEP_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} pae_bus_s;

	typedef struct packed {
		pae_val_t pv;
		pae_val_t sp;
		pae_val_t mv_heat;
		pae_val_t mv_cool;
		pae_val_t rsp;
	} pae_loop_s;

	typedef struct packed {
		logic [NUM_ALARMS-1:0][TW-1:0]  typ;
		logic [NUM_ALARMS-1:0][DW-1:0]  hi;
		logic [NUM_ALARMS-1:0][DW-1:0]  lo;
		logic [NUM_ALARMS-1:0][DLW-1:0] on_dly;
		logic [NUM_ALARMS-1:0][DLW-1:0] off_dly;
		logic [NUM_ALARMS-1:0][DLW-1:0] cnt;
		logic [NUM_ALARMS-1:0]          raw;
		logic [NUM_ALARMS-1:0]          armed;
		logic [NUM_ALARMS-1:0]          out;
		logic [NUM_AUX-1:0][SW-1:0]     aux_sel;
		logic [NUM_AUX-1:0]             aux;
		logic [DW-1:0]                  hys;
		logic                           heat_cool;
		logic [TCW-1:0]                 tick_cnt;
		logic [DW-1:0]                  rdata;
	} pae_state_s;

endpackage

// ---- test/pae_alarm_chk.sv ----
// Port checker for the process alarm evaluator
`timescale 1ns/1ps
module pae_alarm_chk
	import pae_pkg::*;
#(
	parameter int HAS_HEATER = 0
) (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      nrst,
	// Register port
	input wire pae_pkg::pae_bus_s         bus,
	input wire logic [pae_pkg::DW-1:0]    rdata,
	// Outputs
	input wire logic [pae_pkg::NUM_ALARMS-1:0] alarm_out,
	input wire logic [pae_pkg::NUM_AUX-1:0]    aux_out,
	// Heater alarm level
	input wire logic                      heater_alarm
);
	// ----
	// Helpers
	// ----
	// Shadow of the aux selection, which also decides heater dedication
	logic [7:0]         sel_reg;
	logic [NUM_AUX-1:0] exp_aux;
	wire alm_w = bus.addr[7:4] inside {[4'h1:4'h3]};
	wire ty_w  = bus.wr && alm_w && bus.addr[3:0] == OFS_TYPE;
	wire bad_w = bus.wdata > 16'h0013 ||
		(bus.addr[7:4] != 4'h1 && bus.wdata == 16'h000c);
	wire dl_w  = bus.addr[3:0] inside {OFS_ON_DLY, OFS_OFF_DLY};
	wire lm_w  = bus.addr[3:0] inside {OFS_HI, OFS_LO};
	wire ded_w = HAS_HEATER != 0 && sel_reg[3:0] != 4'h1 &&
		sel_reg[7:4] != 4'h1;
	always_ff @(posedge clk) begin
		if (!nrst)
			sel_reg <= (HAS_HEATER != 0) ? 8'h2f : 8'h21;
		else if (bus.wr && bus.addr == ADDR_AUX)
			sel_reg <= bus.wdata[7:0];
	end
	always_comb begin
		for (int j = 0; j < NUM_AUX; j++)
			exp_aux[j] = (sel_reg[4*j+:4] == 4'hf && HAS_HEATER != 0 &&
				heater_alarm) || (sel_reg[4*j+:4] inside {[4'h1:4'h3]} &&
				alarm_out[2'(sel_reg[4*j+:4] - 4'h1)]);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----
	// Assertions
	// ----
	rd_idle_a: assert property (!bus.rd |=> rdata == '0)
		else $error("read data not zero outside a read");
	stat_read_a: assert property (bus.rd && bus.addr == ADDR_STAT |=>
		rdata[10:8] == $past(alarm_out) && rdata[15:11] == '0)
		else $error("status read does not show alarm outputs");
	unmapped_a: assert property (bus.rd &&
		bus.addr inside {[8'h04:8'h0f]} |=> rdata == '0)
		else $error("unmapped read not zero");
	ctrl_read_a: assert property (bus.rd && bus.addr == ADDR_CTRL
		|=> rdata[15:1] == '0)
		else $error("control read shows restart or spare bits");
	type_keep_a: assert property (ty_w && bad_w ##1
		bus.rd && bus.addr == $past(bus.addr) |=>
		rdata != $past(bus.wdata, 2))
		else $error("refused type code was stored");
	type_take_a: assert property (ty_w && !bad_w &&
		!(ded_w && bus.addr[7:4] == 4'h1) ##1
		bus.rd && bus.addr == $past(bus.addr) |=>
		rdata == $past(bus.wdata, 2))
		else $error("legal type code not stored");
	dly_clamp_a: assert property (bus.wr && alm_w && dl_w &&
		bus.wdata > 16'h03e7 ##1 bus.rd && bus.addr == $past(bus.addr)
		|=> rdata == {6'h00, DELAY_MAX})
		else $error("delay above limit not clamped");
	lim_keep_a: assert property (bus.wr && alm_w && lm_w ##1
		bus.rd && bus.addr == $past(bus.addr) |=>
		rdata == $past(bus.wdata, 2))
		else $error("alarm limit not stored");
	aux_route_a: assert property (1'b1 |=> aux_out == $past(exp_aux))
		else $error("aux output does not follow its alarm");
	cover property ($rose(alarm_out[0]));
	cover property ($rose(aux_out[1]));
	cover property (ty_w && bad_w);
endmodule

bind pae_alarm_eval pae_alarm_chk #(.HAS_HEATER(HAS_HEATER)) u_chk (
	.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
	.alarm_out(alarm_out), .aux_out(aux_out),
	.heater_alarm(heater_alarm)
);

// ---- test/pae_alarm_eval_bench.sv ----
// Self-checking testbench for the process alarm evaluator
`timescale 1ns/1ps
module pae_alarm_eval_bench;
	import pae_pkg::*;
	// Short delay step keeps second-scale delays cheap to run
	localparam int TICK = 10;
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	pae_bus_s              bus = '0;
	logic [DW-1:0]         rdata;
	pae_loop_s             want = '0;
	pae_loop_s             loop_in;
	logic                  heat_want = 1'b0;
	logic                  heater_alarm;
	logic [NUM_ALARMS-1:0] alarm_out;
	logic [NUM_AUX-1:0]    aux_out;
	logic [NUM_AUX-1:0]    relay;
	logic [DW-1:0]         rdata_h;
	logic [NUM_ALARMS-1:0] alarm_h;
	logic [NUM_AUX-1:0]    aux_h;
	int                    error_cnt = 0;
	int                    n_compared = 0;

	always #2.5 clk = ~clk;

	pae_alarm_eval #(.HAS_HEATER(0), .TICK_CYCLES(TICK)) dut (
		.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata),
		.loop_in(loop_in), .heater_alarm(heater_alarm),
		.alarm_out(alarm_out), .aux_out(aux_out)
	);
	// Heater variant on the same bus and loop: alarm 1 starts dedicated
	pae_alarm_eval #(.HAS_HEATER(1), .TICK_CYCLES(TICK)) dut_h (
		.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata_h),
		.loop_in(loop_in), .heater_alarm(heater_alarm),
		.alarm_out(alarm_h), .aux_out(aux_h)
	);
	pae_loop_model far (
		.clk(clk), .want(want), .heat_want(heat_want),
		.loop_out(loop_in), .heater_alarm(heater_alarm),
		.aux_in(aux_out), .relay(relay)
	);

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			error_cnt++;
		end
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk) nrst <= 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 chk(rdata, exp);
	endtask
	// Write then read back at once, with no idle cycle between
	task automatic wrrd(input logic [7:0] a, input logic [15:0] d,
		input logic [15:0] exp);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		rd(a, exp);
	endtask
	task automatic wait_out(input logic v, input int n);
		int i;
		for (i = 0; i < n && alarm_out[0] !== v; i++)
			@(negedge clk);
		chk(16'(alarm_out[0]), 16'(v));
		if (alarm_out[0] !== v)
			end_sim();
	endtask
	// Moves only the process value, so standby arming is kept
	task automatic pv_to(input int v, input int e);
		@(posedge clk) want.pv <= 16'(v);
		repeat (6) @(posedge clk);
		#1 chk(16'(alarm_out[0]), 16'(e));
	endtask
	// Type 0 first, so no hysteresis is carried from the last case
	task automatic run_case(input int t, pv, sp, mv, mvc, rsp, hi, lo,
		hc, e);
		wr(8'h10, 16'h0000);
		wr(ADDR_CTRL, 16'(hc));
		@(posedge clk) want <= '{16'(pv), 16'(sp), 16'(mv), 16'(mvc),
			16'(rsp)};
		wr(8'h11, 16'(hi));
		wr(8'h12, 16'(lo));
		wr(8'h10, 16'(t));
		repeat (6) @(posedge clk);
		#1 chk(16'(alarm_out[0]), 16'(e));
	endtask

	// ----
	// Scenarios
	// ----
	initial begin
		do_reset();
		rd(8'h10, 16'h0002);
		chk(rdata_h, 16'h0000);
		@(posedge clk) heat_want <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk(16'({aux_h[0], alarm_h[0]}), 16'h0003);
		rd(ADDR_HYS, 16'h0001);
		rd(8'h13, 16'h0000);
		rd(ADDR_CTRL, 16'h0000);
		rd(8'h05, 16'h0000);
		wrrd(8'h20, 16'h000c, 16'h0002);
		wrrd(8'h30, 16'h0014, 16'h0002);
		wrrd(8'h10, 16'h000c, 16'h000c);
		chk(rdata_h, 16'h0000);
		wrrd(8'h13, 16'h03e8, 16'h03e7);
		wrrd(8'h21, 16'hfffb, 16'hfffb);
		wr(8'h13, 16'h0000);
		wr(8'h20, 16'h0000);
		wr(8'h30, 16'h0000);
		run_case(0, 500, 100, 0, 0, 0, 10, 10, 0, 0);
		run_case(1, 111, 100, 0, 0, 0, 10, 10, 0, 1);
		run_case(1, 105, 100, 0, 0, 0, 10, 10, 0, 0);
		run_case(1, 85, 100, 0, 0, 0, 10, 20, 0, 0);
		run_case(1, 79, 100, 0, 0, 0, 10, 20, 0, 1);
		run_case(2, 110, 100, 0, 0, 0, 10, 0, 0, 1);
		run_case(2, 109, 100, 0, 0, 0, 10, 0, 0, 0);
		run_case(3, 90, 100, 0, 0, 0, 10, 0, 0, 1);
		run_case(4, 100, 100, 0, 0, 0, 10, 10, 0, 1);
		run_case(4, 120, 100, 0, 0, 0, 10, 10, 0, 0);
		run_case(5, 200, 100, 0, 0, 0, 1, 1, 0, 0);
		run_case(5, 100, 100, 0, 0, 0, 1, 1, 0, 0);
		pv_to(200, 0);
		run_case(5, 100, 100, 0, 0, 0, 5, 5, 0, 0);
		pv_to(200, 1);
		run_case(7, 100, 100, 0, 0, 0, 10, 0, 0, 0);
		pv_to(90, 1);
		run_case(6, 110, 100, 0, 0, 0, 10, 0, 0, 0);
		run_case(8, 51, 0, 0, 0, 0, 50, 0, 0, 1);
		run_case(8, 50, 0, 0, 0, 0, 50, 0, 0, 0);
		run_case(8, 3, 0, 0, 0, 0, -5, 0, 0, 1);
		run_case(9, 49, 0, 0, 0, 0, 50, 0, 0, 1);
		run_case(11, 40, 0, 0, 0, 0, 50, 0, 0, 0);
		run_case(14, 0, 100, 0, 0, 0, 50, 0, 0, 1);
		run_case(15, 0, 100, 0, 0, 0, 200, 0, 0, 1);
		run_case(16, 0, 0, 20, 0, 0, 10, 0, 0, 1);
		run_case(17, 0, 0, 5, 0, 0, 10, 0, 0, 1);
		run_case(17, 0, 0, 50, 5, 0, 10, 0, 1, 1);
		run_case(17, 0, 0, 5, 50, 0, 10, 0, 1, 0);
		run_case(18, 0, 0, 0, 0, 60, 50, 0, 0, 1);
		run_case(19, 0, 0, 0, 0, 40, 50, 0, 0, 1);
		run_case(10, 60, 0, 0, 0, 0, 50, 0, 0, 0);
		@(posedge clk) want.pv <= 16'h0028;
		repeat (6) @(posedge clk);
		@(posedge clk) want.pv <= 16'h003c;
		repeat (6) @(posedge clk);
		#1 chk(16'(alarm_out[0]), 16'h0001);
		rd(ADDR_STAT, 16'h0101);
		chk(16'(relay), 16'h0001);
		wr(ADDR_AUX, 16'h0010);
		repeat (3) @(posedge clk);
		#1 chk(16'(relay), 16'h0002);
		wr(ADDR_CTRL, 16'h0002);
		repeat (4) @(posedge clk);
		#1 chk(16'(alarm_out[0]), 16'h0000);
		run_case(8, 0, 0, 0, 0, 0, 50, 0, 0, 0);
		wr(8'h13, 16'h0003);
		wr(8'h14, 16'h0002);
		@(posedge clk) want.pv <= 16'h003c;
		repeat (15) @(posedge clk);
		#1 chk(16'(alarm_out[0]), 16'h0000);
		wait_out(1'b1, 30);
		chk(16'(alarm_h[0]), 16'h0001);
		@(posedge clk) want.pv <= 16'h0000;
		repeat (5) @(posedge clk);
		#1 chk(16'(alarm_out[0]), 16'h0001);
		wait_out(1'b0, 30);
		do_reset();
		rd(8'h13, 16'h0000);
		rd(8'h10, 16'h0002);
		chk(rdata_h, 16'h0000);
		end_sim();
	end
endmodule

// ---- test/pae_loop_model.sv ----
// Far-side model: control loop values in, auxiliary drivers out
`timescale 1ns/1ps
module pae_loop_model
	import pae_pkg::*;
(
	// Clock
	input  wire logic                     clk,
	// Values the scenario asks for
	input  wire pae_pkg::pae_loop_s       want,
	input  wire logic                     heat_want,
	// Toward the evaluator
	output pae_pkg::pae_loop_s            loop_out,
	output logic                          heater_alarm,
	// Auxiliary drivers
	input  wire logic [pae_pkg::NUM_AUX-1:0] aux_in,
	output logic [pae_pkg::NUM_AUX-1:0]   relay
);
	// Loop refreshes once a clock, so new values land one edge late
	always_ff @(posedge clk) begin
		loop_out     <= want;
		heater_alarm <= heat_want;
		relay        <= aux_in;
	end
endmodule
